/* src/rdcb_pkg.sv */
// Constants and types of the radio discrete control and self-test block
package rdcb_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int DEB_TIME_US = 1000;
   localparam int DEB_CYC = DEB_TIME_US * (CLK_HZ / 1_000_000);
   localparam int DEB_W = 16;

   // ---------------------------------------------------------------
   // Pins and test channels
   // ---------------------------------------------------------------
   localparam int NPIN = 3;
   localparam int PIN_RADIO = 0;
   localparam int PIN_TX = 1;
   localparam int PIN_RST = 2;
   localparam int NCH = 8;
   localparam int CH_W = 3;
   localparam logic [NCH-1:0] DEBIL_MASK = 8'h0f;

   // ---------------------------------------------------------------
   // Fault log
   // ---------------------------------------------------------------
   localparam int LOG_DEPTH = 40;
   localparam int LOG_AW = 6;
   localparam int ENT_W = 6;
   localparam logic [1:0] SRC_PBIT = 2'h0;
   localparam logic [1:0] SRC_CONT = 2'h1;
   localparam logic [1:0] SRC_MBIT = 2'h2;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_OPTEN = 8'h04;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_LOGCNT = 8'h0c;
   localparam logic [7:0] A_LOGIDX = 8'h10;
   localparam logic [7:0] A_LOGDAT = 8'h14;
   localparam logic [7:0] A_ACTIVE = 8'h18;
   localparam int CTRL_MBIT = 0;
   localparam int CTRL_CLR = 1;
   localparam logic [NCH-1:0] OPT_RST = 8'hff;
   localparam int ST_RX = 0;
   localparam int ST_TX = 1;
   localparam int ST_HLTH = 2;
   localparam int ST_HELD = 3;
   localparam int ST_INIT = 4;
   localparam int ST_TEST = 5;
   localparam int ST_PINS = 8;

   typedef enum logic [2:0] {
      S_HOLD,
      S_INIT,
      S_PBIT,
      S_RUN,
      S_MBIT
   } rdcb_state_e;

endpackage

/* src/rdcb_top.sv */
// Discrete input control, health output and self-test fault log
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module rdcb_top #(
   parameter int DEB_CYC = rdcb_pkg::DEB_CYC
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic radio_enable_pin,
   input wire logic transmit_enable_pin,
   input wire logic unit_reset_pin,
   input wire logic [7:0] fault_in,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic health_indicator_pin,
   output logic tx_on,
   output logic rx_on,
   output logic unit_run
);

   // ---------------------------------------------------------------
   // Input synchronisers and debounce
   // ---------------------------------------------------------------
   logic [rdcb_pkg::NPIN-1:0] pin_raw;
   logic [rdcb_pkg::NPIN-1:0] pin_f;

   assign pin_raw = {unit_reset_pin, transmit_enable_pin,
                     radio_enable_pin};

   generate
      for (genvar g = 0; g < rdcb_pkg::NPIN; g++)
      begin : g_pin
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic filt_q;
         logic filt_d;
         logic [rdcb_pkg::DEB_W-1:0] cnt_q;
         logic [rdcb_pkg::DEB_W-1:0] cnt_d;

         always_comb
         begin
            cnt_d = cnt_q;
            filt_d = filt_q;
            if (s2_q != s3_q || s3_q == filt_q)
            begin
               cnt_d = '0;
            end
            else if (cnt_q >= rdcb_pkg::DEB_W'(DEB_CYC - 1))
            begin
               filt_d = s3_q;
               cnt_d = '0;
            end
            else
            begin
               cnt_d = cnt_q + 16'h1;
            end
         end

         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               filt_q <= 1'b0;
               cnt_q <= '0;
            end
            else
            begin
               s1_q <= pin_raw[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               filt_q <= filt_d;
               cnt_q <= cnt_d;
            end
         end

         assign pin_f[g] = filt_q;
      end
   endgenerate

   // ---------------------------------------------------------------
   // State declarations
   // ---------------------------------------------------------------
   rdcb_pkg::rdcb_state_e st_q;
   rdcb_pkg::rdcb_state_e st_d;
   logic [rdcb_pkg::CH_W-1:0] step_q;
   logic [rdcb_pkg::CH_W-1:0] step_d;
   logic [rdcb_pkg::NCH-1:0] active_q;
   logic [rdcb_pkg::NCH-1:0] active_d;
   logic [rdcb_pkg::NCH-1:0] opt_q;
   logic [rdcb_pkg::NCH-1:0] opt_d;
   logic mreq_q;
   logic mreq_d;
   logic hlth_q;
   logic hlth_d;
   logic tx_q;
   logic tx_d;
   logic rx_q;
   logic rx_d;
   logic run_q;
   logic run_d;
   logic [rdcb_pkg::LOG_AW-1:0] cnt_q;
   logic [rdcb_pkg::LOG_AW-1:0] cnt_d;
   logic [rdcb_pkg::LOG_AW-1:0] idx_q;
   logic [rdcb_pkg::LOG_AW-1:0] idx_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [rdcb_pkg::ENT_W-1:0] log_q [rdcb_pkg::LOG_DEPTH];
   logic log_we;
   logic [rdcb_pkg::LOG_AW-1:0] log_wa;
   logic [rdcb_pkg::ENT_W-1:0] log_ent;
   logic [rdcb_pkg::NCH-1:0] logged;
   logic [rdcb_pkg::NCH-1:0] fresh;
   logic [1:0] src;
   logic [rdcb_pkg::LOG_AW-1:0] base;
   logic [rdcb_pkg::CH_W-1:0] ch;
   logic wr_ctrl;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [rdcb_pkg::NCH-1:0] lowest(
      input logic [rdcb_pkg::NCH-1:0] v);
      logic [rdcb_pkg::NCH-1:0] r;
      r = '0;
      for (int i = rdcb_pkg::NCH - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = '0;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction

   function automatic logic [rdcb_pkg::CH_W-1:0] enc(
      input logic [rdcb_pkg::NCH-1:0] v);
      logic [rdcb_pkg::CH_W-1:0] r;
      r = '0;
      for (int i = 0; i < rdcb_pkg::NCH; i++)
      begin
         if (v[i])
         begin
            r = rdcb_pkg::CH_W'(i);
         end
      end
      return r;
   endfunction

   function automatic logic in_log(
      input logic [rdcb_pkg::CH_W-1:0] c,
      input logic [rdcb_pkg::LOG_AW-1:0] n);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < rdcb_pkg::LOG_DEPTH; i++)
      begin
         if (rdcb_pkg::LOG_AW'(i) < n && log_q[i][2:0] == c)
         begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // ---------------------------------------------------------------
   // Sequencer, self-test and outputs
   // ---------------------------------------------------------------
   assign wr_ctrl = wr && addr == rdcb_pkg::A_CTRL;

   always_comb
   begin
      st_d = st_q;
      step_d = step_q;
      active_d = active_q;
      mreq_d = mreq_q;
      logged = '0;
      src = rdcb_pkg::SRC_CONT;
      fresh = fault_in & opt_q & ~active_q;
      unique case (st_q)
         rdcb_pkg::S_HOLD:
         begin
            step_d = '0;
            st_d = rdcb_pkg::S_INIT;
         end
         rdcb_pkg::S_INIT:
         begin
            active_d[step_q] = 1'b0;
            step_d = step_q + 3'h1;
            if (step_q == 3'h7)
            begin
               st_d = rdcb_pkg::S_PBIT;
            end
         end
         rdcb_pkg::S_PBIT:
         begin
            src = rdcb_pkg::SRC_PBIT;
            logged[step_q] = fault_in[step_q] & opt_q[step_q];
            active_d = active_q | logged;
            step_d = step_q + 3'h1;
            if (step_q == 3'h7)
            begin
               st_d = rdcb_pkg::S_RUN;
            end
         end
         rdcb_pkg::S_RUN:
         begin
            logged = lowest(fresh);
            active_d = (active_q & fault_in & opt_q) | logged;
            if (mreq_q)
            begin
               mreq_d = 1'b0;
               step_d = '0;
               st_d = rdcb_pkg::S_MBIT;
            end
         end
         rdcb_pkg::S_MBIT:
         begin
            src = rdcb_pkg::SRC_MBIT;
            logged[step_q] = fault_in[step_q] & opt_q[step_q];
            active_d = (active_q & fault_in & opt_q) | logged;
            step_d = step_q + 3'h1;
            if (step_q == 3'h7)
            begin
               st_d = rdcb_pkg::S_RUN;
            end
         end
      endcase
      if (wr_ctrl && wdata[rdcb_pkg::CTRL_MBIT])
      begin
         mreq_d = 1'b1;
      end
      if (!pin_f[rdcb_pkg::PIN_RST])
      begin
         st_d = rdcb_pkg::S_HOLD;
         step_d = '0;
         mreq_d = 1'b0;
         logged = '0;
      end
      run_d = st_d == rdcb_pkg::S_RUN || st_d == rdcb_pkg::S_MBIT;
      hlth_d = run_d && !(|(active_d & rdcb_pkg::DEBIL_MASK));
      rx_d = run_d && pin_f[rdcb_pkg::PIN_RADIO];
      tx_d = rx_d && pin_f[rdcb_pkg::PIN_TX];
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q <= rdcb_pkg::S_HOLD;
         step_q <= '0;
         active_q <= '0;
         mreq_q <= 1'b0;
         hlth_q <= 1'b0;
         tx_q <= 1'b0;
         rx_q <= 1'b0;
         run_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         step_q <= step_d;
         active_q <= active_d;
         mreq_q <= mreq_d;
         hlth_q <= hlth_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         run_q <= run_d;
      end
   end

   // ---------------------------------------------------------------
   // Fault log
   // ---------------------------------------------------------------
   always_comb
   begin
      base = cnt_q;
      if (wr_ctrl && wdata[rdcb_pkg::CTRL_CLR])
      begin
         base = '0;
      end
      ch = enc(logged);
      log_ent = {rdcb_pkg::DEBIL_MASK[ch], src, ch};
      log_wa = base;
      log_we = |logged && !in_log(ch, base) &&
               base < rdcb_pkg::LOG_AW'(rdcb_pkg::LOG_DEPTH);
      cnt_d = log_we ? base + 6'h1 : base;
   end

   always_ff @(posedge clk)
   begin
      if (log_we)
      begin
         log_q[log_wa] <= log_ent;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   // ---------------------------------------------------------------
   // Register port
   // ---------------------------------------------------------------
   always_comb
   begin
      opt_d = opt_q;
      idx_d = idx_q;
      rdata_d = '0;
      if (wr && addr == rdcb_pkg::A_OPTEN)
      begin
         opt_d = wdata[7:0];
      end
      if (wr && addr == rdcb_pkg::A_LOGIDX)
      begin
         idx_d = wdata[5:0];
      end
      if (rd)
      begin
         unique case (addr)
            rdcb_pkg::A_OPTEN:
            begin
               rdata_d[7:0] = opt_q;
            end
            rdcb_pkg::A_STATUS:
            begin
               rdata_d[rdcb_pkg::ST_RX] = rx_q;
               rdata_d[rdcb_pkg::ST_TX] = tx_q;
               rdata_d[rdcb_pkg::ST_HLTH] = hlth_q;
               rdata_d[rdcb_pkg::ST_HELD] = st_q == rdcb_pkg::S_HOLD;
               rdata_d[rdcb_pkg::ST_INIT] = st_q == rdcb_pkg::S_INIT;
               rdata_d[rdcb_pkg::ST_TEST] =
                  st_q == rdcb_pkg::S_PBIT || st_q == rdcb_pkg::S_MBIT;
               rdata_d[rdcb_pkg::ST_PINS +: rdcb_pkg::NPIN] = pin_f;
            end
            rdcb_pkg::A_LOGCNT:
            begin
               rdata_d[5:0] = cnt_q;
            end
            rdcb_pkg::A_LOGIDX:
            begin
               rdata_d[5:0] = idx_q;
            end
            rdcb_pkg::A_LOGDAT:
            begin
               if (idx_q < cnt_q)
               begin
                  rdata_d[5:0] = log_q[idx_q];
               end
            end
            rdcb_pkg::A_ACTIVE:
            begin
               rdata_d[7:0] = active_q;
            end
            default:
            begin
               rdata_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         opt_q <= rdcb_pkg::OPT_RST;
         idx_q <= '0;
         rdata_q <= '0;
      end
      else
      begin
         opt_q <= opt_d;
         idx_q <= idx_d;
         rdata_q <= rdata_d;
      end
   end

   assign rdata = rdata_q;
   assign health_indicator_pin = hlth_q;
   assign tx_on = tx_q;
   assign rx_on = rx_q;
   assign unit_run = run_q;

endmodule

/* tb/rdcb_chk.sv */
// Assertion checker for the discrete control block
`timescale 1ns/1ps
module rdcb_chk #(
   parameter int DEB_CYC = 4
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic radio_enable_pin,
   input wire logic transmit_enable_pin,
   input wire logic unit_reset_pin,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic health_indicator_pin,
   input wire logic tx_on,
   input wire logic rx_on,
   input wire logic unit_run
);
   localparam int LIM = DEB_CYC + 8;
   logic [15:0] rad_q, txp_q, rst_q;
   logic rad_off, txp_off, held;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // ------------------------------
   // Low-time counters of the pins
   // ------------------------------
   function automatic logic [15:0] nxt(logic [15:0] c, logic p);
      return p ? 16'h0 : (&c ? c : c + 16'h1);
   endfunction
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
      begin
         rad_q <= 16'h0;
         txp_q <= 16'h0;
         rst_q <= 16'h0;
      end
      else
      begin
         rad_q <= nxt(rad_q, radio_enable_pin);
         txp_q <= nxt(txp_q, transmit_enable_pin);
         rst_q <= nxt(rst_q, unit_reset_pin);
      end
   assign rad_off = rad_q >= 16'(LIM);
   assign txp_off = txp_q >= 16'(LIM);
   assign held = rst_q >= 16'(LIM);
   sequence quiet_s;
      (!unit_run && !health_indicator_pin) [*8];
   endsequence
   radio_off_a: assert property (rad_off |-> !rx_on && !tx_on)
      else $error("Radio outputs on while radio grounded");
   tx_off_a: assert property (txp_off |-> !tx_on)
      else $error("Transmitter on while grounded");
   tx_pair_a: assert property (tx_on |-> rx_on)
      else $error("Transmitter on without radio");
   reset_hold_a: assert property (held |-> !unit_run &&
      !health_indicator_pin && !rx_on && !tx_on)
      else $error("Unit active while held");
   restart_a: assert property (held && unit_reset_pin |->
      quiet_s ##[1:40] unit_run)
      else $error("Restart sequence wrong");
   health_run_a: assert property (health_indicator_pin |-> unit_run)
      else $error("Health open while not running");
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("Read data outside read slot");
   glitch_hold_a: assert property (
      unit_run && $fell(unit_reset_pin) |=> unit_run [*6])
      else $error("Unit stopped before debounce");
endmodule

bind rdcb_top rdcb_chk #(.DEB_CYC(DEB_CYC)) u_chk (
   .clk(clk),
   .reset_n(reset_n),
   .radio_enable_pin(radio_enable_pin),
   .transmit_enable_pin(transmit_enable_pin),
   .unit_reset_pin(unit_reset_pin),
   .rd(rd),
   .rdata(rdata),
   .health_indicator_pin(health_indicator_pin),
   .tx_on(tx_on),
   .rx_on(rx_on),
   .unit_run(unit_run)
);

/* tb/rdcb_switch.sv */
// Air/ground switch model driving the three control discretes
`timescale 1ns/1ps
module rdcb_switch
(
   input wire logic clk,
   input wire logic on_ground,
   input wire logic radio_req,
   input wire logic tx_req,
   input wire logic reset_req,
   output logic radio_enable_pin,
   output logic transmit_enable_pin,
   output logic unit_reset_pin
);
   always_ff @(posedge clk)
   begin
      radio_enable_pin <= on_ground & radio_req;
      transmit_enable_pin <= on_ground & tx_req;
      unit_reset_pin <= reset_req;
   end
endmodule

/* tb/tb_top.sv */
// Testbench of the discrete control block
`timescale 1ns/1ps
module tb_top;
   localparam int D = 4;
   logic clk, reset_n, wr, rd, on_ground, radio_req, tx_req, reset_req;
   logic radio_enable_pin, transmit_enable_pin, unit_reset_pin;
   logic health_indicator_pin, tx_on, rx_on, unit_run;
   logic [7:0] fault_in, addr;
   logic [31:0] wdata, rdata;
   logic [3:0] o;
   int bad_count, comparisons, cyc;
   assign o = {rx_on, tx_on, health_indicator_pin, unit_run};
   rdcb_switch u_sw (
      .clk(clk),
      .on_ground(on_ground),
      .radio_req(radio_req),
      .tx_req(tx_req),
      .reset_req(reset_req),
      .radio_enable_pin(radio_enable_pin),
      .transmit_enable_pin(transmit_enable_pin),
      .unit_reset_pin(unit_reset_pin)
   );
   rdcb_top #(.DEB_CYC(D)) u_dut (
      .clk(clk),
      .reset_n(reset_n),
      .radio_enable_pin(radio_enable_pin),
      .transmit_enable_pin(transmit_enable_pin),
      .unit_reset_pin(unit_reset_pin),
      .fault_in(fault_in),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .health_indicator_pin(health_indicator_pin),
      .tx_on(tx_on),
      .rx_on(rx_on),
      .unit_run(unit_run)
   );
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic end_sim;
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wreg(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(logic [7:0] a, logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, e);
   endtask
   task automatic pins(logic r, logic t, logic u);
      @(posedge clk);
      radio_req <= r;
      tx_req <= t;
      reset_req <= u;
   endtask
   task automatic flt(logic [7:0] v);
      @(posedge clk);
      fault_in <= v;
      idle(4);
   endtask
   task automatic wrun;
      for (int i = 0; i < 100 && unit_run !== 1'b1; i++)
         @(negedge clk);
   endtask
   task automatic t_regs;
      rchk(rdcb_pkg::A_OPTEN, 32'hff);
      rchk(rdcb_pkg::A_STATUS, 32'h308);
      wreg(rdcb_pkg::A_LOGCNT, 32'h5);
      rchk(rdcb_pkg::A_LOGCNT, 32'h0);
      rchk(8'h1c, 32'h0);
   endtask
   task automatic t_enab;
      pins(1'b1, 1'b1, 1'b1);
      wrun;
      chk(o, 32'hf);
      rchk(rdcb_pkg::A_STATUS, 32'h707);
      for (int i = 0; i < 4; i++)
      begin
         pins(i[1], i[0], 1'b1);
         idle(D + 8);
         chk(o, {i[1], i[1] & i[0], 2'h3});
      end
   endtask
   task automatic t_fault;
      flt(8'h20);
      chk(o, 32'hf);
      wreg(rdcb_pkg::A_LOGIDX, 32'h0);
      rchk(rdcb_pkg::A_LOGDAT, 32'h0d);
      flt(8'h22);
      chk(o, 32'hd);
      wreg(rdcb_pkg::A_LOGIDX, 32'h1);
      rchk(rdcb_pkg::A_LOGDAT, 32'h29);
      rchk(rdcb_pkg::A_ACTIVE, 32'h22);
      wreg(rdcb_pkg::A_OPTEN, 32'hfb);
      flt(8'h24);
      chk(o, 32'hf);
      rchk(rdcb_pkg::A_LOGCNT, 32'h2);
      flt(8'h20);
      wreg(rdcb_pkg::A_OPTEN, 32'hff);
   endtask
   task automatic t_man;
      wreg(rdcb_pkg::A_CTRL, 32'h2);
      rchk(rdcb_pkg::A_LOGCNT, 32'h0);
      wreg(rdcb_pkg::A_LOGIDX, 32'h0);
      wreg(rdcb_pkg::A_CTRL, 32'h1);
      rchk(rdcb_pkg::A_STATUS, 32'h727);
      repeat (12)
      begin
         @(negedge clk);
         chk(o, 32'hf);
      end
      rchk(rdcb_pkg::A_LOGDAT, 32'h15);
   endtask
   task automatic t_rst;
      wreg(rdcb_pkg::A_CTRL, 32'h2);
      pins(1'b1, 1'b1, 1'b0);
      idle(1);
      pins(1'b1, 1'b1, 1'b1);
      idle(D + 8);
      chk(o, 32'hf);
      pins(1'b1, 1'b1, 1'b0);
      idle(D + 8);
      chk(o, 32'h0);
      pins(1'b1, 1'b1, 1'b1);
      wrun;
      chk(o, 32'hf);
      rchk(rdcb_pkg::A_LOGCNT, 32'h1);
      rchk(rdcb_pkg::A_LOGDAT, 32'h05);
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         end_sim;
      end
   end
   initial
   begin
      reset_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h0;
      wdata = 32'h0;
      fault_in = 8'h0;
      on_ground = 1'b1;
      radio_req = 1'b1;
      tx_req = 1'b1;
      reset_req = 1'b0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      idle(20);
      t_regs;
      t_enab;
      t_fault;
      t_man;
      t_rst;
      end_sim;
   end
endmodule
